// File: dvr_volume.v
// digital volume stage with soft ramping, sample fifo and control registers
`timescale 1ns/1ps
`include "dvr_defs.vh"

module dvr_fifo #(
  parameter W  = 48,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         ref_clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] wr_data_i,
  input  wire         wr_valid_i,
  output wire         wr_ready_o,
  output wire [W-1:0] rd_data_o,
  output wire         rd_valid_o,
  input  wire         rd_ready_i
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire         push;
  wire         pop;

  assign wr_ready_o = (count != D[AW:0]);
  assign rd_valid_o = (count != {(AW+1){1'b0}});
  assign rd_data_o  = mem[rd_ptr];
  assign push       = wr_valid_i & wr_ready_o;
  assign pop        = rd_valid_o & rd_ready_i;

  always @(posedge ref_clk_i)
  begin
    if (push)
      mem[wr_ptr] <= wr_data_i;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

module dvr_volume (
  input  wire                     ref_clk_i,
  input  wire                     rst_n_i,
  input  wire                     reg_wr_i,
  input  wire                     reg_rd_i,
  input  wire [7:0]               reg_addr_i,
  input  wire [7:0]               reg_wdata_i,
  output reg  [7:0]               reg_rdata_o,
  input  wire                     emerg_i,
  input  wire [`DVR_SAMPLE_W-1:0] in_left_i,
  input  wire [`DVR_SAMPLE_W-1:0] in_right_i,
  input  wire                     in_valid_i,
  output wire                     in_ready_o,
  output reg  [`DVR_SAMPLE_W-1:0] out_left_o,
  output reg  [`DVR_SAMPLE_W-1:0] out_right_o,
  output reg                      out_valid_o,
  input  wire                     out_ready_i,
  output reg  [7:0]               gain_code_o,
  output reg                      ramp_busy_o
);
  localparam SW = `DVR_SAMPLE_W;

  reg  [7:0]    volume_code;
  reg  [7:0]    ramp_normal;
  reg  [7:0]    ramp_emerg;
  reg  [7:0]    cur_code;
  reg  [1:0]    rate_cnt;
  reg  [7:0]    next_code;
  reg  [1:0]    next_cnt;
  reg  [1:0]    sel_rate;
  reg  [1:0]    sel_step;
  reg  [7:0]    step_amt;
  reg  [8:0]    sum;
  reg  [1:0]    last_cnt;
  reg           in_ready_q;
  wire [7:0]    target;
  wire          going_down;
  wire          fs_tick;
  wire [2*SW-1:0] fifo_rd_data;
  wire          fifo_rd_valid;
  wire          fifo_rd_ready;
  wire          fifo_wr_ready;
  wire [SW-1:0] scaled [0:1];

  // mute target on fault; plain code otherwise
  assign target     = emerg_i ? `DVR_CODE_MUTE : volume_code;
  assign going_down = (target > cur_code);
  // one accepted sample pair marks one sample period
  assign fs_tick    = in_valid_i & in_ready_q & fifo_wr_ready;
  assign in_ready_o = in_ready_q;

  // ready is held high after reset whatever the fifo space, registered so the port comes from a flop
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      in_ready_q <= 1'b0;
    else
      in_ready_q <= 1'b1;
  end

  // register writes
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      volume_code <= `DVR_RST_VOLUME;
      ramp_normal <= `DVR_RST_RAMP_NORMAL;
      ramp_emerg  <= `DVR_RST_RAMP_EMERG;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `DVR_OFS_VOLUME)
        volume_code <= reg_wdata_i;
      else if (reg_addr_i == `DVR_OFS_RAMP_NORMAL)
        ramp_normal <= reg_wdata_i;
      else if (reg_addr_i == `DVR_OFS_RAMP_EMERG)
        ramp_emerg <= reg_wdata_i;
    end
  end

  // register reads, unmapped reads return zero
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      if (reg_addr_i == `DVR_OFS_VOLUME)
        reg_rdata_o <= volume_code;
      else if (reg_addr_i == `DVR_OFS_STATUS)
        reg_rdata_o <= cur_code;
      else if (reg_addr_i == `DVR_OFS_RAMP_NORMAL)
        reg_rdata_o <= ramp_normal;
      else if (reg_addr_i == `DVR_OFS_RAMP_EMERG)
        reg_rdata_o <= ramp_emerg;
      else
        reg_rdata_o <= 8'h00;
    end
  end

  // ramp setting selection and next gain
  always @*
  begin
    if (emerg_i)
    begin
      sel_rate = ramp_emerg[`DVR_DOWN_RATE_HI:`DVR_DOWN_RATE_LO];
      sel_step = ramp_emerg[`DVR_DOWN_STEP_HI:`DVR_DOWN_STEP_LO];
    end
    else if (going_down)
    begin
      sel_rate = ramp_normal[`DVR_DOWN_RATE_HI:`DVR_DOWN_RATE_LO];
      sel_step = ramp_normal[`DVR_DOWN_STEP_HI:`DVR_DOWN_STEP_LO];
    end
    else
    begin
      sel_rate = ramp_normal[`DVR_UP_RATE_HI:`DVR_UP_RATE_LO];
      sel_step = ramp_normal[`DVR_UP_STEP_HI:`DVR_UP_STEP_LO];
    end
    case (sel_step)
      2'h0: step_amt = `DVR_STEP_4DB;
      2'h1: step_amt = `DVR_STEP_2DB;
      2'h2: step_amt = `DVR_STEP_1DB;
      default: step_amt = `DVR_STEP_HALF_DB;
    endcase
    case (sel_rate)
      2'h0: last_cnt = 2'h0;
      2'h1: last_cnt = 2'h1;
      default: last_cnt = 2'h3;
    endcase
    if (going_down)
      sum = {1'b0, cur_code} + {1'b0, step_amt};
    else
      sum = {1'b0, cur_code} - {1'b0, step_amt};
    next_code = cur_code;
    next_cnt  = 2'h0;
    if (fs_tick && (cur_code != target))
    begin
      if (sel_rate == `DVR_RATE_INSTANT)
        next_code = target;
      else if (rate_cnt >= last_cnt)
      begin
        if (going_down)
          next_code = (sum >= {1'b0, target}) ? target : sum[7:0];
        else
          next_code = (sum[8] || (sum[7:0] <= target)) ? target : sum[7:0];
      end
      else
        next_cnt = rate_cnt + 2'h1;
    end
    else if (!fs_tick)
      next_cnt = (cur_code != target) ? rate_cnt : 2'h0;
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cur_code    <= `DVR_RST_VOLUME;
      rate_cnt    <= 2'h0;
      gain_code_o <= `DVR_RST_VOLUME;
      ramp_busy_o <= 1'b0;
    end
    else
    begin
      cur_code    <= next_code;
      rate_cnt    <= next_cnt;
      gain_code_o <= next_code;
      ramp_busy_o <= (next_code != target);
    end
  end

  dvr_fifo #(
    .W  (2*SW),
    .D  (`DVR_FIFO_DEPTH),
    .AW (`DVR_FIFO_AW)
  ) u_fifo (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_data_i  ({in_left_i, in_right_i}),
    .wr_valid_i (in_valid_i & in_ready_q),
    .wr_ready_o (fifo_wr_ready),
    .rd_data_o  (fifo_rd_data),
    .rd_valid_o (fifo_rd_valid),
    .rd_ready_i (fifo_rd_ready)
  );

  assign fifo_rd_ready = !out_valid_o || out_ready_i;

  // per-channel gain, same code on both channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      reg  [15:0]        mant;
      reg  [5:0]         shamt;
      reg  signed [40:0] prod;
      reg  signed [40:0] shifted;
      reg  [SW-1:0]      res;
      wire signed [SW-1:0] smp;
      wire [7:0]         octave;
      wire [7:0]         frac;

      assign smp    = fifo_rd_data[ch*SW +: SW];
      assign octave = cur_code / `DVR_CODES_PER_OCTAVE;
      assign frac   = cur_code - octave * `DVR_CODES_PER_OCTAVE;

      always @*
      begin
        case (frac[3:0])
          4'h0: mant = 16'h8000;
          4'h1: mant = 16'h78d7;
          4'h2: mant = 16'h7215;
          4'h3: mant = 16'h6bb3;
          4'h4: mant = 16'h65ad;
          4'h5: mant = 16'h5ffd;
          4'h6: mant = 16'h5a9e;
          4'h7: mant = 16'h558c;
          4'h8: mant = 16'h50c3;
          4'h9: mant = 16'h4c3f;
          4'ha: mant = 16'h47fb;
          default: mant = 16'h43f4;
        endcase
        shamt   = `DVR_MANT_FRAC - `DVR_BOOST_SHIFT + octave[5:0];
        prod    = smp * $signed({1'b0, mant});
        shifted = prod >>> shamt;
        if (cur_code == `DVR_CODE_MUTE)
          res = {SW{1'b0}};
        else if (!shifted[40] && (shifted[39:SW-1] != {(41-SW){1'b0}}))
          res = {1'b0, {(SW-1){1'b1}}};
        else if (shifted[40] && (shifted[39:SW-1] != {(41-SW){1'b1}}))
          res = {1'b1, {(SW-1){1'b0}}};
        else
          res = shifted[SW-1:0];
      end
      assign scaled[ch] = res;
    end
  endgenerate

  // output holding stage
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_left_o  <= {SW{1'b0}};
      out_right_o <= {SW{1'b0}};
      out_valid_o <= 1'b0;
    end
    else if (fifo_rd_ready)
    begin
      out_valid_o <= fifo_rd_valid;
      if (fifo_rd_valid)
      begin
        out_left_o  <= scaled[1];
        out_right_o <= scaled[0];
      end
    end
  end
endmodule

// File: dvr_defs.vh
// constants for the digital volume soft-ramp stage
`ifndef DVR_DEFS_VH
`define DVR_DEFS_VH

`define DVR_OFS_VOLUME       8'h4c
`define DVR_OFS_STATUS       8'h4d
`define DVR_OFS_RAMP_NORMAL  8'h4e
`define DVR_OFS_RAMP_EMERG   8'h4f

`define DVR_RST_VOLUME       8'h30
`define DVR_RST_RAMP_NORMAL  8'h33
`define DVR_RST_RAMP_EMERG   8'h30

`define DVR_CODE_UNITY       8'h30
`define DVR_CODE_MUTE        8'hff

`define DVR_DOWN_RATE_HI     7
`define DVR_DOWN_RATE_LO     6
`define DVR_DOWN_STEP_HI     5
`define DVR_DOWN_STEP_LO     4
`define DVR_UP_RATE_HI       3
`define DVR_UP_RATE_LO       2
`define DVR_UP_STEP_HI       1
`define DVR_UP_STEP_LO       0

`define DVR_RATE_INSTANT     2'h3
`define DVR_STEP_4DB         8'h08
`define DVR_STEP_2DB         8'h04
`define DVR_STEP_1DB         8'h02
`define DVR_STEP_HALF_DB     8'h01

`define DVR_CODES_PER_OCTAVE 8'h0c
`define DVR_BOOST_SHIFT      6'h04
`define DVR_MANT_FRAC        6'h0f

`define DVR_SAMPLE_W         24
`define DVR_FIFO_DEPTH       8
`define DVR_FIFO_AW          3

`endif

// File: dvr_volume_asserts.sv
// port checker for the volume stage
`timescale 1ns/1ps
module dvr_volume_asserts (
  input logic        ref_clk_i,
  input logic        rst_n_i,
  input logic        reg_wr_i,
  input logic        reg_rd_i,
  input logic [7:0]  reg_addr_i,
  input logic [7:0]  reg_wdata_i,
  input logic [7:0]  reg_rdata_o,
  input logic        emerg_i,
  input logic        in_valid_i,
  input logic        in_ready_o,
  input logic [23:0] out_left_o,
  input logic [23:0] out_right_o,
  input logic        out_valid_o,
  input logic        out_ready_i,
  input logic [7:0]  gain_code_o
);
  logic [7:0] sh_nrm;
  logic [7:0] sh_emg;
  logic       inst;
  // shadow of the ramp settings
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      sh_nrm <= 8'h33;
      sh_emg <= 8'h30;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == 8'h4e)
        sh_nrm <= reg_wdata_i;
      if (reg_addr_i == 8'h4f)
        sh_emg <= reg_wdata_i;
    end
  assign inst = sh_nrm[7:6] == 2'h3 || sh_nrm[3:2] == 2'h3 || sh_emg[7:6] == 2'h3;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_tick;
    in_valid_i && in_ready_o;
  endsequence
  sequence s_muted;
    (gain_code_o == 8'hff) [*3];
  endsequence
  AST_GAIN_TICK: assert property ($changed(gain_code_o) |-> $past(in_valid_i && in_ready_o))
    else $error("gain moved without a sample");
  AST_STEP_BOUND: assert property (!inst && $changed(gain_code_o) |->
    (gain_code_o > $past(gain_code_o) ? gain_code_o - $past(gain_code_o)
     : $past(gain_code_o) - gain_code_o) <= 8'h08) else $error("gain step too large");
  AST_STATUS_READ: assert property (reg_rd_i && reg_addr_i == 8'h4d |=>
    reg_rdata_o == $past(gain_code_o)) else $error("status read wrong");
  AST_RESET_GAIN: assert property ($rose(rst_n_i) |-> gain_code_o == 8'h30)
    else $error("gain not unity after reset");
  AST_MUTE_OUT: assert property (s_muted ##0 out_ready_i ##1 out_valid_o |->
    out_left_o == 24'h000000 && out_right_o == 24'h000000) else $error("muted output nonzero");
  AST_EMERG_DOWN: assert property ($past(emerg_i) |-> gain_code_o >= $past(gain_code_o))
    else $error("gain rose during fault");
  AST_MUTE_HOLD: assert property (emerg_i && gain_code_o == 8'hff |=> gain_code_o == 8'hff)
    else $error("fault mute left");
  AST_OUT_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o &&
    $stable(out_left_o) && $stable(out_right_o)) else $error("output dropped while stalled");
  cover property (s_tick ##1 $changed(gain_code_o));
endmodule

// File: dvr_volume_bench.sv
// self-checking bench for the volume stage
`timescale 1ns/1ps
module dvr_volume_bench;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        emerg_i = 1'b0;
  logic [23:0] in_left_i = 24'h000000;
  logic [23:0] in_right_i = 24'h000000;
  logic        in_valid_i = 1'b0;
  logic        out_ready_i = 1'b1;
  wire  [7:0]  reg_rdata_o;
  wire  [7:0]  gain_code_o;
  wire  [23:0] out_left_o;
  wire  [23:0] out_right_o;
  wire         in_ready_o;
  wire         out_valid_o;
  wire         ramp_busy_o;
  int          n_fail = 0;
  int          checks_done = 0;
  int          k;
  always #12.5 ref_clk_i = ~ref_clk_i;
  dvr_volume dut_u (.*);
  task end_of_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk8(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk24(string nm, logic [23:0] e, logic [23:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task rc(logic [7:0] a, logic [7:0] e);
    @(negedge ref_clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    chk8($sformatf("reg %h", a), e, reg_rdata_o);
  endtask
  // n back-to-back samples, then the applied code
  task tk(int n, logic [7:0] e);
    @(negedge ref_clk_i);
    in_valid_i = 1'b1;
    repeat (n) @(negedge ref_clk_i);
    in_valid_i = 1'b0;
    chk8("gain", e, gain_code_o);
  endtask
  task smp(logic [23:0] l, logic [23:0] r);
    repeat (4) @(negedge ref_clk_i);
    in_left_i = l;
    in_right_i = r;
    in_valid_i = 1'b1;
    @(negedge ref_clk_i);
    in_valid_i = 1'b0;
    k = 0;
    while (out_valid_o !== 1'b1 && k < 10)
    begin
      @(negedge ref_clk_i);
      k++;
    end
    if (out_valid_o !== 1'b1)
    begin
      n_fail++;
      end_of_test();
    end
  endtask
  initial
  begin
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    rc(8'h4c, 8'h30);
    chk8("ready", 8'h01, {7'h00, in_ready_o});
    rc(8'h4e, 8'h33);
    rc(8'h4f, 8'h30);
    rc(8'h4d, 8'h30);
    wr(8'h4a, 8'h55);
    rc(8'h4a, 8'h00);
    wr(8'h4f, 8'h3c);
    rc(8'h4f, 8'h3c);
    wr(8'h4c, 8'h34);
    tk(1, 8'h31);
    chk8("busy", 8'h01, {7'h00, ramp_busy_o});
    tk(3, 8'h34);
    chk8("busy", 8'h00, {7'h00, ramp_busy_o});
    wr(8'h4e, 8'ha3);
    wr(8'h4c, 8'h44);
    tk(3, 8'h34);
    tk(1, 8'h36);
    tk(28, 8'h44);
    wr(8'h4e, 8'h35);
    wr(8'h4c, 8'h3e);
    tk(2, 8'h40);
    tk(2, 8'h3e);
    wr(8'h4e, 8'hff);
    wr(8'h4c, 8'hff);
    tk(1, 8'hff);
    smp(24'h123456, 24'h654321);
    chk24("mute left", 24'h000000, out_left_o);
    chk24("mute right", 24'h000000, out_right_o);
    wr(8'h4c, 8'h30);
    tk(1, 8'h30);
    wr(8'h4e, 8'h33);
    smp(24'h001000, 24'h000800);
    chk24("left", 24'h001000, out_left_o);
    chk24("right", 24'h000800, out_right_o);
    // fill the fifo with the sink stalled, then drain
    out_ready_i = 1'b0;
    tk(12, 8'h30);
    out_ready_i = 1'b1;
    k = 0;
    repeat (20)
    begin
      @(negedge ref_clk_i);
      k += int'(out_valid_o === 1'b1);
    end
    chk8("beats", 8'h08, k[7:0]);
    wr(8'h4f, 8'h50);
    emerg_i = 1'b1;
    tk(2, 8'h34);
    tk(110, 8'hff);
    emerg_i = 1'b0;
    tk(1, 8'hfe);
    // 4 dB steps, instant and slow ramp up, instant fault mute
    wr(8'h4e, 8'h0c);
    tk(1, 8'h30);
    wr(8'h4c, 8'h40);
    tk(1, 8'h38);
    tk(1, 8'h40);
    wr(8'h4e, 8'h08);
    wr(8'h4c, 8'h30);
    tk(3, 8'h40);
    tk(1, 8'h38);
    wr(8'h4f, 8'hc0);
    emerg_i = 1'b1;
    tk(1, 8'hff);
    emerg_i = 1'b0;
    rst_n_i = 1'b0;
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    rc(8'h4f, 8'h30);
    chk8("gain", 8'h30, gain_code_o);
    end_of_test();
  end
endmodule
bind dvr_volume dvr_volume_asserts chk_u (.*);
